// ===== rtl/chop_filter_regs.vh
// constants for the chopped sinc filter timing core
`ifndef CHOP_FILTER_REGS_VH
`define CHOP_FILTER_REGS_VH
`define MCLK_PER_WORD 1024
`define DIV_WIDTH 10
`define DIV_MIN 10'h001
`define DIV_MAX 10'h3FF
`define DIV_RESET 10'h060
`define PH_SINC4 3'h4
`define PH_THIRD_ORDER_FILTER_SELECT 3'h3
`define DATA_WIDTH 24
`define SETTLE_CONVS 2'h2
`endif

// ===== rtl/phase_timer.v
// counts master clock enables in blocks of 1024 times the divider word
`timescale 1ns/1ps
`include "chop_filter_regs.vh"
module phase_timer (
  input wire clock,
  input wire rst,
  input wire restart,
  input wire mclkEn,
  input wire [9:0] divWord,
  input wire [2:0] phases,
  output reg phaseDone
);
  reg [9:0] subCnt_q;
  reg [9:0] wordCnt_q;
  reg [2:0] phCnt_q;
  wire [9:0] divEff = (divWord == 10'h000) ? `DIV_MIN : divWord;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      subCnt_q <= 10'h000;
      wordCnt_q <= 10'h000;
      phCnt_q <= 3'h0;
      phaseDone <= 1'b0;
    end else if (restart) begin
      subCnt_q <= 10'h000;
      wordCnt_q <= 10'h000;
      phCnt_q <= 3'h0;
      phaseDone <= 1'b0;
    end else begin
      phaseDone <= 1'b0;
      if (mclkEn) begin
        // one period is phases x 1024 x divider master clocks
        if (subCnt_q == 10'h3FF) begin
          subCnt_q <= 10'h000;
          if (wordCnt_q == divEff - 10'h001) begin
            wordCnt_q <= 10'h000;
            if (phCnt_q == phases - 3'h1) begin
              phCnt_q <= 3'h0;
              phaseDone <= 1'b1;
            end else begin
              phCnt_q <= phCnt_q + 3'h1;
            end
          end else begin
            wordCnt_q <= wordCnt_q + 10'h001;
          end
        end else begin
          subCnt_q <= subCnt_q + 10'h001;
        end
      end
    end
  end
endmodule // phase_timer

// ===== rtl/chopped_sinc_filter_timing.v
// timing core of the chopped sinc decimation filter
`timescale 1ns/1ps
`include "chop_filter_regs.vh"
module chopped_sinc_filter_timing (
  input wire clock,
  input wire rst,
  input wire mclkEn,
  input wire chopEnable,
  input wire third_order_filter_select,
  input wire notch_sixty_hz_select,
  input wire [9:0] rate_divider_word,
  input wire channelChange,
  input wire [23:0] sincResult,
  output reg modulatorReset,
  output reg filterReset,
  output reg polarityInvert,
  output reg resultValid,
  output reg [23:0] resultData,
  output reg settled,
  output reg notchSixtyActive
);
  localparam ST_RESET = 2'h0;
  localparam ST_FIRST = 2'h1;
  localparam ST_RUN = 2'h2;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [1:0] sinceStart_q;
  reg [1:0] sinceStart_d;
  reg [23:0] prevSample_q;
  reg chop_q;
  reg order_q;
  reg [9:0] div_q;
  reg emit;
  wire phaseDone;
  wire cfgChange;
  wire newSeq;
  wire restart;
  wire running;
  wire periodEnd;
  wire [2:0] phases;

  // signed mean of two words; the carry bit keeps the sum from overflowing, and the half LSB is dropped
  function [23:0] average2;
    input [23:0] a;
    input [23:0] b;
    reg [24:0] s;
    begin
      s = {a[23], a} + {b[23], b};
      average2 = s[24:1];
    end
  endfunction

  // a zero divider word runs as one, so it never stalls the timer
  function [9:0] clampDiv;
    input [9:0] w;
    begin
      clampDiv = (w == 10'h000) ? `DIV_MIN : w;
    end
  endfunction

  // chop on pairs opposite-polarity words; chop off passes the word through
  function [23:0] pairOut;
    input chopOn;
    input [23:0] cur;
    input [23:0] prev;
    begin
      pairOut = chopOn ? average2(cur, prev) : cur;
    end
  endfunction

  // sinc4 uses four word-blocks per period, third_order_filter_select three; chop-off unclaimed here
  assign phases = order_q ? `PH_THIRD_ORDER_FILTER_SELECT : `PH_SINC4;
  // compared against the clamped word, or a zero word would restart forever
  assign cfgChange = (chopEnable != chop_q) || (third_order_filter_select != order_q)
    || (clampDiv(rate_divider_word) != div_q);
  assign newSeq = channelChange || cfgChange;
  assign restart = newSeq || (state_q == ST_RESET);
  assign running = (state_q == ST_FIRST) || (state_q == ST_RUN);
  assign periodEnd = phaseDone && running && !newSeq;

  phase_timer u_timer (
    .clock(clock),
    .rst(rst),
    .restart(restart),
    .mclkEn(mclkEn),
    .divWord(div_q),
    .phases(phases),
    .phaseDone(phaseDone)
  );

  // next sequence step; a new sequence overrides whatever was in flight
  always @* begin
    state_d = state_q;
    sinceStart_d = sinceStart_q;
    emit = 1'b0;
    if (newSeq) begin
      state_d = ST_FIRST;
      sinceStart_d = 2'h0;
    end else begin
      case (state_q)
        ST_RESET: begin
          state_d = ST_FIRST;
        end
        ST_FIRST: begin
          // two periods pass before the first averaged pair exists
          if (phaseDone) begin
            if (sinceStart_q == `SETTLE_CONVS - 2'h1) begin
              emit = 1'b1;
              state_d = ST_RUN;
            end else begin
              sinceStart_d = sinceStart_q + 2'h1;
            end
          end
        end
        ST_RUN: begin
          // steps are not detected: cadence continues, averaging lags two results
          emit = phaseDone;
        end
        default: begin
          state_d = ST_RESET;
        end
      endcase
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      state_q <= ST_RESET;
      sinceStart_q <= 2'h0;
    end else begin
      state_q <= state_d;
      sinceStart_q <= sinceStart_d;
    end
  end

  // configuration copy, reloaded only when a new sequence starts
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      chop_q <= 1'b0;
      order_q <= 1'b0;
      div_q <= `DIV_RESET;
    end else if (newSeq) begin
      chop_q <= chopEnable;
      order_q <= third_order_filter_select;
      div_q <= clampDiv(rate_divider_word);
    end
  end

  // both resets held during rst and pulsed once per new sequence
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      modulatorReset <= 1'b1;
      filterReset <= 1'b1;
    end else begin
      modulatorReset <= newSeq;
      filterReset <= newSeq;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      polarityInvert <= 1'b0;
    end else if (newSeq) begin
      polarityInvert <= 1'b0;
    end else if (periodEnd && chop_q) begin
      polarityInvert <= ~polarityInvert;
    end
  end

  // the word of the period just ended waits here for its opposite-polarity partner
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      prevSample_q <= 24'h000000;
    end else if (periodEnd) begin
      prevSample_q <= sincResult;
    end
  end

  always @(posedge clock or posedge rst) begin
    if (rst) begin
      resultValid <= 1'b0;
      resultData <= 24'h000000;
      settled <= 1'b0;
    end else begin
      resultValid <= emit;
      if (emit) begin
        resultData <= pairOut(chop_q, sincResult, prevSample_q);
      end
      if (newSeq) begin
        settled <= 1'b0;
      end else if (emit) begin
        settled <= 1'b1;
      end
    end
  end

  // the notch select is only registered onto notchSixtyActive; period counting ignores it
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      notchSixtyActive <= 1'b0;
    end else begin
      notchSixtyActive <= notch_sixty_hz_select;
    end
  end
endmodule // chopped_sinc_filter_timing

// ===== testbench/modulator_model.sv
// stand-in for the modulator: master clock ticks and polarity-dependent sinc words
`timescale 1ns/1ps
module modulator_model (
  input wire clock,
  input wire rst,
  input wire polarityInvert,
  output reg mclkEn,
  output wire [23:0] sincResult
);
  reg [3:0] phase_q;
  // eight ticks in nine clocks: gating is exercised and periods stay whole clock counts
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      phase_q <= 4'h0;
      mclkEn <= 1'b0;
    end else begin
      phase_q <= (phase_q == 4'h8) ? 4'h0 : phase_q + 4'h1;
      mclkEn <= (phase_q != 4'h8);
    end
  end
  // each polarity reads a different word, so only a true pair average gives the midpoint
  assign sincResult = polarityInvert ? 24'h000100 : 24'h000300;
endmodule // modulator_model

// ===== testbench/chop_timing_sva.sv
// assertions on the ports of the chopped sinc timing core
`timescale 1ns/1ps
module chop_timing_sva (
  input wire clock,
  input wire rst,
  input wire channelChange,
  input wire chopEnable,
  input wire notch_sixty_hz_select,
  input wire [9:0] rate_divider_word,
  input wire modulatorReset,
  input wire filterReset,
  input wire polarityInvert,
  input wire resultValid,
  input wire [23:0] resultData,
  input wire settled
);
  reg [13:0] sinceCnt_q;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  sequence restartSeq;
    modulatorReset && filterReset;
  endsequence
  // saturates so a long run cannot wrap into a false short settle
  always @(posedge clock or posedge rst) begin
    if (rst || modulatorReset)
      sinceCnt_q <= 14'h0000;
    else if (sinceCnt_q != 14'h3FFF)
      sinceCnt_q <= sinceCnt_q + 14'h0001;
  end
  chan_restart_a: assert property (channelChange |=> restartSeq) else $error("no restart");
  reset_pair_a: assert property (modulatorReset |-> filterReset) else $error("split reset");
  cfg_restart_a: assert property ($changed(rate_divider_word) |-> ##[1:2] restartSeq)
    else $error("divider change kept running");
  settle_time_a: assert property (resultValid |-> sinceCnt_q >= 14'd6000)
    else $error("result before settling");
  valid_pulse_a: assert property (resultValid |=> !resultValid) else $error("valid too long");
  settled_flag_a: assert property (resultValid |-> settled) else $error("settled low");
  restart_clear_a: assert property (restartSeq |-> !settled) else $error("settled kept");
  pol_swap_a: assert property (resultValid && $past(chopEnable) |-> $changed(polarityInvert))
    else $error("polarity kept");
  data_hold_a: assert property ($changed(resultData) |-> resultValid) else $error("data moved");
  notch_keep_a: assert property ($changed(notch_sixty_hz_select) && !channelChange
    |=> !modulatorReset [*2]) else $error("notch select restarted");
endmodule // chop_timing_sva
bind chopped_sinc_filter_timing chop_timing_sva chop_timing_sva_i (.*);

// ===== testbench/chopped_sinc_filter_timing_bench.sv
// self-checking bench for the chopped sinc timing core
`timescale 1ns/1ps
module chopped_sinc_filter_timing_bench;
  reg clock = 0, rst = 1, chop = 1, sel3 = 1, n60 = 0, chg = 0;
  reg [9:0] div = 10'h001;
  reg [26:0] rows [0:1];
  wire mclkEn, modRst, filtRst, pol, valid, settled, n60Act;
  wire [23:0] sinc, data;
  integer n_fail = 0, num_checks = 0, cyc = 0, i, w, p;
  chopped_sinc_filter_timing chopped_sinc_filter_timing_i (.clock(clock), .rst(rst),
    .mclkEn(mclkEn), .chopEnable(chop), .third_order_filter_select(sel3),
    .notch_sixty_hz_select(n60), .rate_divider_word(div), .channelChange(chg),
    .sincResult(sinc), .modulatorReset(modRst), .filterReset(filtRst),
    .polarityInvert(pol), .resultValid(valid), .resultData(data), .settled(settled),
    .notchSixtyActive(n60Act));
  modulator_model modulator_model_i (.clock(clock), .rst(rst), .polarityInvert(pol),
    .mclkEn(mclkEn), .sincResult(sinc));
  initial forever #12.5 clock = !clock;
  task give_verdict;
    begin
      if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  task check(input [95:0] nm, input [23:0] exp, input [23:0] got);
    begin
      num_checks = num_checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("mismatch %0s expected %0h seen %0h", nm, exp, got);
      end
    end
  endtask
  task waitValid(output integer n);
    begin
      // looked at mid-cycle, where the registered pulse has settled
      n = 0;
      @(negedge clock);
      while (valid !== 1'b1 && n < 45000) begin
        n = n + 1;
        @(negedge clock);
      end
    end
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 95000) begin
      n_fail = n_fail + 1;
      give_verdict;
    end
  end
  initial begin
    // rows: third_order_filter_select select, divider word, period in clocks at eight ticks per nine clocks
    rows[0] = {1'b1, 10'h006, 16'h5100};
    rows[1] = {1'b0, 10'h001, 16'h1200};
    repeat (20) @(posedge clock);
    check("rstOut", 24'h3, {22'h0, modRst, filtRst});
    rst <= 0;
    for (i = 0; i < 2; i = i + 1) begin
      p = rows[i][15:0];
      sel3 <= rows[i][26];
      div <= rows[i][25:16];
      chg <= 1;
      @(posedge clock) chg <= 0;
      waitValid(w);
      check("first", 24'h1, 24'(w >= 2 * p - 4 && w <= 2 * p + 4));
      check("avg", 24'h000200, data);
      check("settled", 24'h1, {23'h0, settled});
      waitValid(w);
      check("period", 24'(p), 24'(w + 1));
      @(posedge clock);
    end
    n60 <= 1;
    waitValid(w);
    check("notchRate", 24'(p), 24'(w + 1));
    check("notchOn", 24'h1, {23'h0, n60Act});
    @(posedge clock) chg <= 1;
    @(posedge clock) chg <= 0;
    @(negedge clock);
    check("chgRst", 24'h3, {22'h0, modRst, filtRst});
    check("chgClear", 24'h0, {23'h0, settled});
    @(posedge clock) chop <= 0;
    waitValid(w);
    check("chopFirst", 24'h1, 24'(w >= 2 * p - 4 && w <= 2 * p + 4));
    check("rawData", 24'h000300, data);
    @(posedge clock) rst <= 1;
    @(negedge clock);
    check("midRst", 24'hC, {20'h0, modRst, filtRst, valid, settled});
    check("midData", 24'h0, data);
    @(posedge clock) rst <= 0;
    repeat (2) @(negedge clock);
    check("relSettle", 24'h0, {23'h0, settled});
    give_verdict;
  end
endmodule // chopped_sinc_filter_timing_bench
